//--- rtl/partcfg_pkg.sv
// Shared constants for the port and partition configuration link
package partcfg_pkg;
  // ==========================================================
  // Packet types and header layout
  localparam logic [7:0] TYPE_SET_ASSIGN = 8'h28;
  localparam logic [7:0] TYPE_GET_PORT   = 8'h29;
  localparam logic [7:0] TYPE_SET_PORT   = 8'h2a;
  localparam logic [7:0] RSP_FLAG        = 8'h80;
  localparam logic [7:0] HDR_REV         = 8'h01;
  localparam logic [7:0] CHANNEL_ID      = 8'h00;
  localparam logic [7:0] MC_ID           = 8'h00;
  localparam int         OFS_REV         = 1;
  localparam int         OFS_IID         = 3;
  localparam int         OFS_TYPE        = 4;
  localparam int         OFS_CHAN        = 5;
  localparam int         OFS_LEN_HI      = 6;
  localparam int         OFS_LEN_LO      = 7;
  localparam int         HDR_LEN         = 16;
  // ==========================================================
  // Body lengths in bytes, checksum excluded
  localparam logic [6:0] SET_ASSIGN_BODY = 7'h14;
  localparam logic [6:0] GET_PORT_BODY   = 7'h10;
  localparam logic [6:0] SET_PORT_BODY   = 7'h2c;
  localparam logic [6:0] RSP_SHORT_BODY  = 7'h14;
  localparam logic [6:0] RSP_PORT_BODY   = 7'h30;
  localparam int         RX_DEPTH        = 64;
  // ==========================================================
  // Payload fields
  localparam int         OFS_PAYLOAD     = 16;
  localparam int         OFS_SHARE_RSP   = 28;
  localparam int         OFS_SHARE_SET   = 24;
  localparam int         NUM_PART        = 10;
  localparam logic [7:0] FABRIC_MASK     = 8'h07;
  localparam logic [7:0] SERVICE_MASK    = 8'h3f;
  localparam logic [7:0] SHARE_MAX       = 8'h64;
  localparam int         MEDIA_BACKPLANE = 0;
  localparam int         MEDIA_COPPER    = 1;
  localparam int         MEDIA_CAGE      = 2;
  localparam int         MEDIA_SHARED    = 7;
  localparam logic [15:0] RSP_OK         = 16'h0000;
  localparam logic [15:0] RSP_FAIL       = 16'h0001;
  localparam logic [15:0] REASON_NONE    = 16'h0000;
  localparam logic [15:0] REASON_UNKNOWN = 16'h7fff;
  // ==========================================================
  // Controller register offsets
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_BUS_MAP  = 8'h04;
  localparam logic [7:0] REG_PORT_CFG = 8'h08;
  localparam logic [7:0] REG_PORT_CNT = 8'h0c;
  localparam logic [7:0] REG_SHARE0   = 8'h10;
  localparam logic [7:0] REG_RSP_CODE = 8'h24;
  localparam logic [7:0] REG_RSP_TYPE = 8'h28;
  localparam logic [7:0] REG_RSP_CFG0 = 8'h2c;
  localparam logic [7:0] REG_RSP_CFG1 = 8'h30;
  localparam int         SHARE_WORDS  = 5;

  function automatic logic [7:0] share_clip(input logic [7:0] v);
    return (v > SHARE_MAX) ? SHARE_MAX : v;
  endfunction : share_clip
endpackage : partcfg_pkg

//--- rtl/partcfg_link_if.sv
// Byte-wide command and response link between the two ends
interface partcfg_link_if (
  input wire logic ref_clk,
  input wire logic sys_rst
);
  logic       cmd_valid;
  logic       cmd_last;
  logic [7:0] cmd_data;
  logic       rsp_valid;
  logic       rsp_last;
  logic [7:0] rsp_data;

  modport controller (
    output cmd_valid, cmd_last, cmd_data,
    input  rsp_valid, rsp_last, rsp_data
  );
  modport device (
    input  cmd_valid, cmd_last, cmd_data,
    output rsp_valid, rsp_last, rsp_data
  );
endinterface : partcfg_link_if

//--- rtl/partcfg_device.sv
// Network controller end: parses configuration commands, answers them
// ==========================================================
// How it works
// - Bus assignment bitmap is 32 bits wide
// - Bitmap bit n marks function n assigned
// - Good assignment command answered with 0xA8
// - Assignment answer: header, codes, checksum
// - Port query holds header and checksum only
// - Good port query answered with 0xA9
// - Port query answer uses generic codes only
// - Port answer field layout, checksum at 48
// - Media bits: backplane, copper, cage
// - Media bit 7 shared, bits 3-6 zero
// - Cage port reports cage despite copper module
// - Feature field, bits 7-15 reserved
// - Maximum share byte per enabled partition
// - Minimum share byte per enabled partition
// - Controller configures port with 0x2A
// - Set command field layout from byte 16
// - Fabric bits: Ethernet, Fibre Channel, third
// - Set command accepted, answered with 0xAA
// - Share bytes hold 0 to 100 percent
// - Assignment takes effect at bus reset
//
// Local design decisions: the plain strobed port and the register offsets.
module partcfg_device
  import partcfg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  partcfg_link_if.device   link,
  input  wire logic        host_bus_rst,
  input  wire logic        port_backplane,
  input  wire logic        port_copper,
  input  wire logic        port_cage,
  input  wire logic        port_shared,
  input  wire logic [6:0]  feature_support,
  output logic      [31:0] bus_function_map,
  output logic      [2:0]  fabric_enable,
  output logic      [7:0]  service_class_kind,
  output logic      [7:0]  largest_frame_size,
  output logic      [7:0]  partition_count,
  output logic      [79:0] partition_max_tx_share,
  output logic      [79:0] partition_min_tx_share
);
  typedef enum logic [3:0] {
    ST_RECV = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_BODY = 4'b0100,
    ST_SUM = 4'b1000
  } dev_state_t;

  dev_state_t  state_reg;
  logic [7:0]  rx_mem [0:RX_DEPTH-1];
  logic [6:0]  rx_cnt_reg;
  logic [7:0]  rx_hi_reg;
  logic [15:0] rx_w1_reg;
  logic        rx_have_reg;
  logic [31:0] rx_sum_reg;
  logic        rx_ok_reg;
  logic [15:0] rx_word;
  logic [31:0] pending_map_reg;
  logic [7:0]  rsp_type_reg;
  logic [15:0] rsp_code_reg;
  logic [15:0] rsp_reason_reg;
  logic        rsp_port_reg;
  logic [6:0]  tx_len_reg;
  logic [6:0]  tx_idx_reg;
  logic [7:0]  tx_hi_reg;
  logic [31:0] tx_sum_reg;
  logic [31:0] tx_chk;
  logic [7:0]  tx_byte;
  logic [7:0]  media_byte;
  logic [7:0]  cmd_type;
  logic        cmd_good;
  logic        rsp_valid_reg;
  logic        rsp_last_reg;
  logic [7:0]  rsp_data_reg;

  assign rx_word  = {rx_hi_reg, link.cmd_data};
  assign cmd_type = rx_mem[OFS_TYPE];
  assign cmd_good = rx_ok_reg && rx_mem[OFS_REV] == HDR_REV &&
                    rx_mem[OFS_CHAN] == CHANNEL_ID;
  assign tx_chk   = 32'h0 - tx_sum_reg;

  // Cage wins over copper: a copper module in a cage is still a cage
  assign media_byte = {port_shared, 4'h0, port_cage,
                       port_copper & ~port_cage, port_backplane};

  // ==========================================================
  // Sequencing
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_RECV;
    end else begin
      case (state_reg)
        ST_RECV: begin
          if (link.cmd_valid && link.cmd_last) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // Bad checksum or wrong identifier: dropped silently
          state_reg <= cmd_good ? ST_BODY : ST_RECV;
        end
        ST_BODY: begin
          if (tx_idx_reg == tx_len_reg - 7'h1) begin
            state_reg <= ST_SUM;
          end
        end
        ST_SUM: begin
          if (tx_idx_reg == 7'h3) begin
            state_reg <= ST_RECV;
          end
        end
        default: state_reg <= ST_RECV;
      endcase
    end
  end

  // ==========================================================
  // Command capture and checksum; bytes arriving while busy are lost
  always_ff @(posedge ref_clk) begin
    if (state_reg == ST_RECV && link.cmd_valid &&
        rx_cnt_reg < 7'(RX_DEPTH)) begin
      rx_mem[rx_cnt_reg[5:0]] <= link.cmd_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_cnt_reg  <= 7'h0;
      rx_hi_reg   <= 8'h0;
      rx_w1_reg   <= 16'h0;
      rx_have_reg <= 1'b0;
      rx_sum_reg  <= 32'h0;
      rx_ok_reg   <= 1'b0;
    end else if (state_reg == ST_RECV && link.cmd_valid) begin
      if (link.cmd_last) begin
        rx_cnt_reg  <= 7'h0;
        rx_have_reg <= 1'b0;
        rx_sum_reg  <= 32'h0;
        rx_ok_reg   <= rx_cnt_reg[0] && rx_have_reg &&
                       rx_cnt_reg < 7'(RX_DEPTH) &&
                       rx_sum_reg + {rx_w1_reg, rx_word} == 32'h0;
      end else begin
        if (rx_cnt_reg != 7'h7f) begin
          rx_cnt_reg <= rx_cnt_reg + 7'h1;
        end
        if (rx_cnt_reg[0]) begin
          // Last two words are held back: they may be the checksum
          if (rx_have_reg) begin
            rx_sum_reg <= rx_sum_reg + {16'h0, rx_w1_reg};
          end
          rx_w1_reg   <= rx_word;
          rx_have_reg <= 1'b1;
        end else begin
          rx_hi_reg <= link.cmd_data;
        end
      end
    end
  end

  // ==========================================================
  // Command effects and answer selection
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_type_reg   <= 8'h0;
      rsp_code_reg   <= RSP_OK;
      rsp_reason_reg <= REASON_NONE;
      rsp_port_reg   <= 1'b0;
      tx_len_reg     <= RSP_SHORT_BODY;
    end else if (state_reg == ST_CHECK && cmd_good) begin
      rsp_type_reg   <= cmd_type | RSP_FLAG;
      rsp_port_reg   <= cmd_type == TYPE_GET_PORT;
      tx_len_reg     <= (cmd_type == TYPE_GET_PORT) ?
                        RSP_PORT_BODY : RSP_SHORT_BODY;
      case (cmd_type)
        TYPE_SET_ASSIGN, TYPE_GET_PORT, TYPE_SET_PORT: begin
          rsp_code_reg   <= RSP_OK;
          rsp_reason_reg <= REASON_NONE;
        end
        default: begin
          rsp_code_reg   <= RSP_FAIL;
          rsp_reason_reg <= REASON_UNKNOWN;
        end
      endcase
    end
  end

  // Assignment is held and only applied on a host bus reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_map_reg  <= 32'h0;
      bus_function_map <= 32'h0;
    end else begin
      if (state_reg == ST_CHECK && cmd_good &&
          cmd_type == TYPE_SET_ASSIGN) begin
        pending_map_reg <= {rx_mem[16], rx_mem[17],
                            rx_mem[18], rx_mem[19]};
      end
      if (host_bus_rst) begin
        bus_function_map <= pending_map_reg;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fabric_enable          <= 3'h0;
      service_class_kind     <= 8'h0;
      largest_frame_size     <= 8'h0;
      partition_count        <= 8'h0;
      partition_max_tx_share <= 80'h0;
      partition_min_tx_share <= 80'h0;
    end else if (state_reg == ST_CHECK && cmd_good &&
                 cmd_type == TYPE_SET_PORT) begin
      // Media and feature bytes describe hardware and are not stored
      fabric_enable      <= rx_mem[16][2:0];
      service_class_kind <= rx_mem[17] & SERVICE_MASK;
      largest_frame_size <= rx_mem[18];
      partition_count    <= rx_mem[23];
      for (int p = 0; p < NUM_PART; p++) begin
        partition_max_tx_share[8*p +: 8] <=
          share_clip(rx_mem[OFS_SHARE_SET + 2*p]);
        partition_min_tx_share[8*p +: 8] <=
          share_clip(rx_mem[OFS_SHARE_SET + 2*p + 1]);
      end
    end
  end

  // ==========================================================
  // Answer byte generation
  always_comb begin
    tx_byte = 8'h00;
    if (tx_idx_reg < 7'(HDR_LEN)) begin
      tx_byte = rx_mem[tx_idx_reg[5:0]];
      if (tx_idx_reg == 7'(OFS_TYPE)) begin
        tx_byte = rsp_type_reg;
      end else if (tx_idx_reg == 7'(OFS_LEN_HI)) begin
        tx_byte = 8'h00;
      end else if (tx_idx_reg == 7'(OFS_LEN_LO)) begin
        tx_byte = {1'b0, tx_len_reg - 7'(HDR_LEN)};
      end
    end else begin
      case (tx_idx_reg)
        7'h10: tx_byte = rsp_code_reg[15:8];
        7'h11: tx_byte = rsp_code_reg[7:0];
        7'h12: tx_byte = rsp_reason_reg[15:8];
        7'h13: tx_byte = rsp_reason_reg[7:0];
        7'h14: tx_byte = {5'h0, fabric_enable};
        7'h15: tx_byte = service_class_kind;
        7'h16: tx_byte = largest_frame_size;
        7'h17: tx_byte = media_byte;
        7'h19: tx_byte = {1'b0, feature_support};
        7'h1b: tx_byte = partition_count;
        default: begin
          if (tx_idx_reg >= 7'(OFS_SHARE_RSP)) begin
            tx_byte = tx_idx_reg[0] ?
              partition_min_tx_share[8*((tx_idx_reg - 7'h1c) >> 1) +: 8] :
              partition_max_tx_share[8*((tx_idx_reg - 7'h1c) >> 1) +: 8];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_idx_reg    <= 7'h0;
      tx_hi_reg     <= 8'h0;
      tx_sum_reg    <= 32'h0;
      rsp_valid_reg <= 1'b0;
      rsp_last_reg  <= 1'b0;
      rsp_data_reg  <= 8'h0;
    end else begin
      rsp_valid_reg <= 1'b0;
      rsp_last_reg  <= 1'b0;
      case (state_reg)
        ST_CHECK: begin
          tx_idx_reg <= 7'h0;
          tx_sum_reg <= 32'h0;
        end
        ST_BODY: begin
          rsp_valid_reg <= 1'b1;
          rsp_data_reg  <= tx_byte;
          if (tx_idx_reg[0]) begin
            tx_sum_reg <= tx_sum_reg + {16'h0, tx_hi_reg, tx_byte};
          end else begin
            tx_hi_reg <= tx_byte;
          end
          tx_idx_reg <= (tx_idx_reg == tx_len_reg - 7'h1) ?
                        7'h0 : tx_idx_reg + 7'h1;
        end
        ST_SUM: begin
          rsp_valid_reg <= 1'b1;
          rsp_data_reg  <= tx_chk[8*(3 - tx_idx_reg[1:0]) +: 8];
          rsp_last_reg  <= tx_idx_reg == 7'h3;
          tx_idx_reg    <= tx_idx_reg + 7'h1;
        end
        default: tx_idx_reg <= 7'h0;
      endcase
    end
  end

  assign link.rsp_valid = rsp_valid_reg;
  assign link.rsp_last  = rsp_last_reg;
  assign link.rsp_data  = rsp_data_reg;
endmodule : partcfg_device

//--- rtl/partcfg_controller.sv
// Management controller end: builds commands from registers, logs answers
module partcfg_controller
  import partcfg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  partcfg_link_if.controller link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  typedef enum logic [2:0] {
    CT_IDLE = 3'b001,
    CT_BODY = 3'b010,
    CT_SUM = 3'b100
  } ctl_state_t;

  ctl_state_t  state_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [7:0]  type_reg;
  logic [7:0]  iid_reg;
  logic [31:0] bus_map_reg;
  logic [31:0] port_cfg_reg;
  logic [31:0] port_cnt_reg;
  logic [31:0] share_reg [0:SHARE_WORDS-1];
  logic [6:0]  len_reg;
  logic [6:0]  idx_reg;
  logic [7:0]  hi_reg;
  logic [31:0] sum_reg;
  logic [31:0] chk;
  logic [7:0]  cmd_byte;
  logic [6:0]  rx_idx_reg;
  logic [31:0] rsp_code_reg;
  logic [7:0]  rsp_type_reg;
  logic [31:0] rsp_cfg0_reg;
  logic [31:0] rsp_cfg1_reg;
  logic        cmd_valid_reg;
  logic        cmd_last_reg;
  logic [7:0]  cmd_data_reg;
  logic        start;

  assign start = reg_wr && reg_addr == REG_CMD && !busy_reg;
  assign chk   = 32'h0 - sum_reg;

  // ==========================================================
  // Software registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_map_reg  <= 32'h0;
      port_cfg_reg <= 32'h0;
      port_cnt_reg <= 32'h0;
      type_reg     <= TYPE_GET_PORT;
      for (int i = 0; i < SHARE_WORDS; i++) begin
        share_reg[i] <= 32'h0;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CMD:      if (!busy_reg) type_reg <= reg_wdata[7:0];
        REG_BUS_MAP:  bus_map_reg  <= reg_wdata;
        REG_PORT_CFG: port_cfg_reg <= reg_wdata;
        REG_PORT_CNT: port_cnt_reg <= reg_wdata;
        default: begin
          for (int i = 0; i < SHARE_WORDS; i++) begin
            if (reg_addr == REG_SHARE0 + 8'(4*i)) begin
              share_reg[i] <= reg_wdata;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CMD:      reg_rdata <= {22'h0, done_reg, busy_reg, type_reg};
        REG_BUS_MAP:  reg_rdata <= bus_map_reg;
        REG_PORT_CFG: reg_rdata <= port_cfg_reg;
        REG_PORT_CNT: reg_rdata <= port_cnt_reg;
        REG_RSP_CODE: reg_rdata <= rsp_code_reg;
        REG_RSP_TYPE: reg_rdata <= {24'h0, rsp_type_reg};
        REG_RSP_CFG0: reg_rdata <= rsp_cfg0_reg;
        REG_RSP_CFG1: reg_rdata <= rsp_cfg1_reg;
        default: begin
          reg_rdata <= 32'h0;
          for (int i = 0; i < SHARE_WORDS; i++) begin
            if (reg_addr == REG_SHARE0 + 8'(4*i)) begin
              reg_rdata <= share_reg[i];
            end
          end
        end
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ==========================================================
  // Command byte generation; fields sit high byte first in each word
  always_comb begin
    cmd_byte = 8'h00;
    case (idx_reg)
      7'(OFS_REV):    cmd_byte = HDR_REV;
      7'(OFS_IID):    cmd_byte = iid_reg;
      7'(OFS_TYPE):   cmd_byte = type_reg;
      7'(OFS_CHAN):   cmd_byte = CHANNEL_ID;
      7'(OFS_LEN_LO): cmd_byte = {1'b0, len_reg - 7'(HDR_LEN)};
      default: begin
        if (idx_reg < 7'(HDR_LEN)) begin
          cmd_byte = (idx_reg == 7'h0) ? MC_ID : 8'h00;
        end else if (idx_reg < 7'h14) begin
          cmd_byte = (type_reg == TYPE_SET_ASSIGN) ?
            bus_map_reg[8*(3 - idx_reg[1:0]) +: 8] :
            port_cfg_reg[8*(3 - idx_reg[1:0]) +: 8];
          if (idx_reg == 7'h10 && type_reg == TYPE_SET_PORT) begin
            cmd_byte = port_cfg_reg[31:24] & FABRIC_MASK;
          end
        end else if (idx_reg < 7'h18) begin
          cmd_byte = port_cnt_reg[8*(3 - idx_reg[1:0]) +: 8];
        end else begin
          cmd_byte = share_reg[3'((idx_reg - 7'h18) >> 2)]
                              [8*(3 - idx_reg[1:0]) +: 8];
        end
      end
    endcase
  end

  // ==========================================================
  // Send sequence; one command in flight until its answer ends
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= CT_IDLE;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      iid_reg       <= 8'h0;
      len_reg       <= GET_PORT_BODY;
      idx_reg       <= 7'h0;
      hi_reg        <= 8'h0;
      sum_reg       <= 32'h0;
      cmd_valid_reg <= 1'b0;
      cmd_last_reg  <= 1'b0;
      cmd_data_reg  <= 8'h0;
    end else begin
      cmd_valid_reg <= 1'b0;
      cmd_last_reg  <= 1'b0;
      if (link.rsp_valid && link.rsp_last) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end
      case (state_reg)
        CT_IDLE: begin
          if (start) begin
            busy_reg  <= 1'b1;
            done_reg  <= 1'b0;
            iid_reg   <= iid_reg + 8'h1;
            idx_reg   <= 7'h0;
            sum_reg   <= 32'h0;
            state_reg <= CT_BODY;
            case (reg_wdata[7:0])
              TYPE_SET_ASSIGN: len_reg <= SET_ASSIGN_BODY;
              TYPE_SET_PORT:   len_reg <= SET_PORT_BODY;
              default:         len_reg <= GET_PORT_BODY;
            endcase
          end
        end
        CT_BODY: begin
          cmd_valid_reg <= 1'b1;
          cmd_data_reg  <= cmd_byte;
          if (idx_reg[0]) begin
            sum_reg <= sum_reg + {16'h0, hi_reg, cmd_byte};
          end else begin
            hi_reg <= cmd_byte;
          end
          if (idx_reg == len_reg - 7'h1) begin
            idx_reg   <= 7'h0;
            state_reg <= CT_SUM;
          end else begin
            idx_reg <= idx_reg + 7'h1;
          end
        end
        CT_SUM: begin
          cmd_valid_reg <= 1'b1;
          cmd_data_reg  <= chk[8*(3 - idx_reg[1:0]) +: 8];
          cmd_last_reg  <= idx_reg == 7'h3;
          idx_reg       <= idx_reg + 7'h1;
          if (idx_reg == 7'h3) begin
            state_reg <= CT_IDLE;
          end
        end
        default: state_reg <= CT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Answer capture; the answer checksum is not verified here
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_idx_reg   <= 7'h0;
      rsp_code_reg <= 32'h0;
      rsp_type_reg <= 8'h0;
      rsp_cfg0_reg <= 32'h0;
      rsp_cfg1_reg <= 32'h0;
    end else if (link.rsp_valid) begin
      rx_idx_reg <= link.rsp_last ? 7'h0 : rx_idx_reg + 7'h1;
      if (rx_idx_reg == 7'(OFS_TYPE)) begin
        rsp_type_reg <= link.rsp_data;
      end
      case (rx_idx_reg[6:2])
        5'h4: rsp_code_reg[8*(3 - rx_idx_reg[1:0]) +: 8] <= link.rsp_data;
        5'h5: rsp_cfg0_reg[8*(3 - rx_idx_reg[1:0]) +: 8] <= link.rsp_data;
        5'h6: rsp_cfg1_reg[8*(3 - rx_idx_reg[1:0]) +: 8] <= link.rsp_data;
        default: ;
      endcase
    end
  end

  assign link.cmd_valid = cmd_valid_reg;
  assign link.cmd_last  = cmd_last_reg;
  assign link.cmd_data  = cmd_data_reg;
endmodule : partcfg_controller

//--- tb/partcfg_sva.sv
// Protocol checker for the configuration link between the two ends
module partcfg_sva
  import partcfg_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       cmd_valid,
  input wire logic       cmd_last,
  input wire logic [7:0] cmd_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_last,
  input wire logic [7:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Answer byte position, so field checks need no packet copy
  logic [7:0] idx_reg;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      idx_reg <= 8'h00;
    else if (rsp_valid)
      idx_reg <= rsp_last ? 8'h00 : idx_reg + 8'h01;
  end
  a_cmd_last_pulse:
    assert property (cmd_last |-> cmd_valid ##1 !cmd_last)
    else $error("cmd_last not a single valid cycle");
  a_answer_soon:
    assert property (cmd_last |-> ##[1:4] rsp_valid)
    else $error("no answer after command");
  a_rsp_contig:
    assert property (rsp_valid && !rsp_last |=> rsp_valid)
    else $error("answer bytes not contiguous");
  a_no_overlap:
    assert property (rsp_valid |-> !cmd_valid)
    else $error("command and answer overlap");
  a_type_flag:
    assert property (rsp_valid && idx_reg == 8'h04 |-> rsp_data[7])
    else $error("answer type lacks top bit");
  a_answer_len:
    assert property (rsp_last |-> idx_reg == 8'h17 || idx_reg == 8'h33)
    else $error("answer length wrong");
  // Byte 23 is the media byte only in the long answer, not its last byte
  a_media_rsvd:
    assert property (rsp_valid && !rsp_last && idx_reg == 8'h17
      |-> rsp_data[6:3] == 4'h0)
    else $error("media reserved bits set");
  a_cage_only:
    assert property (rsp_valid && !rsp_last && idx_reg == 8'h17
      |-> !(rsp_data[2] && rsp_data[1]))
    else $error("cage reported with copper");
  a_share_cap:
    assert property (rsp_valid && idx_reg >= 8'h1c && idx_reg < 8'h30
      |-> rsp_data <= SHARE_MAX)
    else $error("share above limit");
endmodule : partcfg_sva

//--- tb/port_partition_config_commands_tb.sv
// Self-checking bench for controller and device joined by the link
module port_partition_config_commands_tb
  import partcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, host_bus_rst = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  strap = 4'h0;
  logic [6:0]  feat = 7'h00;
  logic [7:0]  reg_addr = 8'h00, cls, mtu, cnt;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, bmap;
  logic [2:0]  fab;
  logic [79:0] pmax, pmin;
  int          n_mismatch = 0, num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  partcfg_link_if link (.ref_clk(ref_clk), .sys_rst(sys_rst));
  partcfg_device partcfg_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link(link), .host_bus_rst(host_bus_rst), .port_backplane(strap[0]),
    .port_copper(strap[1]), .port_cage(strap[2]), .port_shared(strap[3]),
    .feature_support(feat), .bus_function_map(bmap), .fabric_enable(fab),
    .service_class_kind(cls), .largest_frame_size(mtu),
    .partition_count(cnt), .partition_max_tx_share(pmax),
    .partition_min_tx_share(pmin));
  partcfg_controller partcfg_controller_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  partcfg_sva partcfg_sva_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cmd_valid(link.cmd_valid), .cmd_last(link.cmd_last),
    .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid),
    .rsp_last(link.rsp_last), .rsp_data(link.rsp_data));
  // ==========================================================
  // Expectations and bus tasks
  function automatic logic [7:0] cap(input logic [7:0] v);
    return (v > 8'h64) ? 8'h64 : v;
  endfunction : cap
  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  // Polls until idle with done set; a dropped command stops the poll after 100 reads and fails the done check
  task automatic run(input logic [7:0] t, input logic [31:0] exp_type);
    logic [31:0] q;
    wr(REG_CMD, {24'h0, t});
    for (int i = 0; i < 100; i++) begin
      rd(REG_CMD, q);
      if (q[9] === 1'b1 && q[8] === 1'b0) break;
    end
    chk("done", 32'h200, {22'h0, q[9:8], 8'h0});
    rd(REG_RSP_TYPE, q);
    chk("answer type", exp_type, q);
    rd(REG_RSP_CODE, q);
    chk("code", (t == 8'h3c) ? {RSP_FAIL, REASON_UNKNOWN} : 32'h0, q);
  endtask : run
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #200us;
    n_mismatch++;
    final_report();
  end
  // ==========================================================
  // Tests: set port, query port, set assignment
  initial begin
    logic [31:0] cfg, fc, w, q, old;
    logic [31:0] sh [5];
    old = 32'h0;
    void'($urandom(32'h73382181));
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      strap <= k ? 4'h6 : 4'($urandom);
      feat <= 7'($urandom);
      cfg = $urandom;
      fc = $urandom;
      wr(REG_PORT_CFG, cfg);
      wr(REG_PORT_CNT, fc);
      for (int i = 0; i < 5; i++) begin
        sh[i] = k ? 32'h64ff0065 : $urandom;
        wr(REG_SHARE0 + 8'(4 * i), sh[i]);
      end
      run(TYPE_SET_PORT, 32'haa);
      chk("fabric", {29'h0, cfg[26:24]}, {29'h0, fab});
      chk("class", {26'h0, cfg[21:16]}, {24'h0, cls});
      chk("frame", {24'h0, cfg[15:8]}, {24'h0, mtu});
      chk("count", {24'h0, fc[7:0]}, {24'h0, cnt});
      for (int p = 0; p < 10; p++) begin
        chk("max", {24'h0, cap(sh[p/2][31-16*(p%2) -: 8])},
          {24'h0, pmax[8*p +: 8]});
        chk("min", {24'h0, cap(sh[p/2][23-16*(p%2) -: 8])},
          {24'h0, pmin[8*p +: 8]});
      end
      run(TYPE_GET_PORT, 32'ha9);
      rd(REG_RSP_CFG0, q);
      chk("cfg0", {5'h0, cfg[26:24], 2'h0, cfg[21:16], cfg[15:8], strap[3],
        4'h0, strap[2], strap[1] & ~strap[2], strap[0]}, q);
      rd(REG_RSP_CFG1, q);
      chk("cfg1", {9'h0, feat, 8'h0, fc[7:0]}, q);
      run(8'h3c, 32'hbc);
      w = k ? 32'h8000ffff : $urandom;
      wr(REG_BUS_MAP, w);
      run(TYPE_SET_ASSIGN, 32'ha8);
      chk("map held", old, bmap);
      @(posedge ref_clk);
      host_bus_rst <= 1'b1;
      @(posedge ref_clk);
      host_bus_rst <= 1'b0;
      @(posedge ref_clk);
      #1 chk("map", w, bmap);
      old = w;
      rd(8'hfc, q);
      chk("unmapped", 32'h0, q);
      $display("test %0d done", k);
    end
    final_report();
  end
endmodule : port_partition_config_commands_tb
